// *** sec_pkg.sv ***
// constants, types and decode helpers of the serial eeprom command engine
`default_nettype none
package sec_pkg;

  // ---------------------------------------------------------------
  // timing of the self-timed write cycle
  // ---------------------------------------------------------------
  localparam int WC_TIME_NS    = 5000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WC_CYCLES     = WC_TIME_NS / CLK_PERIOD_NS;
  localparam int WC_CNT_W      = 16;
  localparam logic [WC_CNT_W-1:0] WC_COUNT = WC_CNT_W'(WC_CYCLES);
  // cycles lost between the chip select rise and the timer start
  localparam logic [WC_CNT_W-1:0] WC_LAT   = 16'h0004;
  localparam logic [WC_CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [WC_CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [WC_CNT_W-1:0] PAGE_CNT = 16'h0010;

  // ---------------------------------------------------------------
  // array, page and status layout
  // ---------------------------------------------------------------
  localparam int         MEM_WORDS     = 256;
  localparam int         PAGE_BYTES    = 16;
  localparam int         BUSY_BIT      = 0;
  localparam int         LATCH_BIT     = 1;
  localparam int         BP_LO_BIT     = 2;
  localparam logic [3:0] STATUS_PAD    = 4'h0;
  localparam logic [1:0] BP_RESET      = 2'h0;
  localparam logic       LATCH_RESET   = 1'b0;
  localparam logic       CS_PREV_RESET = 1'b1;
  localparam logic [2:0] BIT_FIRST     = 3'h0;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] BIT_ONE       = 3'h1;
  localparam logic [7:0] ADDR_STEP     = 8'h01;
  localparam logic [3:0] PAGE_STEP     = 4'h1;
  localparam logic [7:0] PROT_QTR      = 8'hc0;
  localparam logic [7:0] PROT_HALF     = 8'h80;

  // ---------------------------------------------------------------
  // opcodes, commands and link phases
  // ---------------------------------------------------------------
  localparam logic [3:0] OPC_HI    = 4'h0;
  localparam logic [2:0] OPC_READ  = 3'h3;
  localparam logic [2:0] OPC_WRITE = 3'h2;
  localparam logic [2:0] OPC_SET   = 3'h6;
  localparam logic [2:0] OPC_CLR   = 3'h4;
  localparam logic [2:0] OPC_SRD   = 3'h5;
  localparam logic [2:0] OPC_SWR   = 3'h1;

  typedef enum logic [2:0] {
    SEC_NONE = 3'b000, SEC_READ = 3'b001, SEC_WRITE = 3'b010, SEC_SET = 3'b011,
    SEC_CLR  = 3'b100, SEC_SRD  = 3'b101, SEC_SWR   = 3'b110
  } sec_cmd_e;

  typedef enum logic [2:0] {
    SEC_OPC   = 3'b000, SEC_ADDR = 3'b001, SEC_RDATA = 3'b010, SEC_WDATA = 3'b011,
    SEC_SOUT  = 3'b100, SEC_SIN  = 3'b101, SEC_DONE  = 3'b110, SEC_IGN   = 3'b111
  } sec_phase_e;

  // bit 3 of the opcode is a don't-care
  function automatic sec_cmd_e sec_decode(input logic [7:0] op);
    sec_cmd_e c;
    c = SEC_NONE;
    if (op[7:4] == OPC_HI) begin
      case (op[2:0])
        OPC_READ:  c = SEC_READ;
        OPC_WRITE: c = SEC_WRITE;
        OPC_SET:   c = SEC_SET;
        OPC_CLR:   c = SEC_CLR;
        OPC_SRD:   c = SEC_SRD;
        OPC_SWR:   c = SEC_SWR;
        default:   c = SEC_NONE;
      endcase
    end
    return c;
  endfunction : sec_decode

  function automatic logic sec_protected(input logic [7:0] a, input logic [1:0] bp);
    logic p;
    case (bp)
      2'h0:    p = 1'b0;
      2'h1:    p = (a >= PROT_QTR);
      2'h2:    p = (a >= PROT_HALF);
      default: p = 1'b1;
    endcase
    return p;
  endfunction : sec_protected

endpackage : sec_pkg
`default_nettype wire

// *** sec_wc_if.sv ***
// handshake between the command engine and its write-cycle timer
`timescale 1ns/10ps
`default_nettype none
interface sec_wc_if;
  import sec_pkg::*;
  logic                start;
  logic                busy;
  logic [WC_CNT_W-1:0] count;
  modport engine (output start, input busy, input count);
  modport timer  (input start, output busy, output count);
endinterface : sec_wc_if
`default_nettype wire

// *** sec_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module sec_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // level in, synchronised level out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  import sec_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sec_sync_s;

  sec_sync_s q_r;
  sec_sync_s q_nxt;

  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = i_d;
    q_nxt.s2 = q_r.s1;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r.s2;
endmodule : sec_sync
`default_nettype wire

// *** sec_wc_timer.sv ***
// self-timed write cycle timer
`timescale 1ns/10ps
`default_nettype none
module sec_wc_timer #(
  parameter logic [sec_pkg::WC_CNT_W-1:0] CYCLES = sec_pkg::WC_COUNT
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // engine handshake
  sec_wc_if.timer   wc
);
  import sec_pkg::*;

  typedef struct packed {
    logic                busy;
    logic [WC_CNT_W-1:0] cnt;
  } sec_tmr_s;

  sec_tmr_s q_r;
  sec_tmr_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (q_r.busy) begin
      q_nxt.cnt = q_r.cnt + CNT_ONE;
      // ends early enough to cover the chip select synchroniser
      if (q_r.cnt == CYCLES - WC_LAT) begin
        q_nxt.busy = 1'b0;
      end
    end else if (wc.start) begin
      q_nxt.busy = 1'b1;
      q_nxt.cnt  = CNT_ZERO;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign wc.busy  = q_r.busy;
  assign wc.count = q_r.cnt;

  busy_limit_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    q_r.busy |-> q_r.cnt <= CYCLES - WC_LAT)
    else $error("write cycle overran its limit");

  cover_cycle_end: cover property (@(posedge i_clock) disable iff (!i_resetn) $fell(q_r.busy));
endmodule : sec_wc_timer
`default_nettype wire

// *** sec_engine.sv ***
// serial eeprom command engine: link shifter, write control and array
`timescale 1ns/10ps
`default_nettype none
module sec_engine #(
  parameter logic [sec_pkg::WC_CNT_W-1:0] WC_CYCLES_P = sec_pkg::WC_COUNT
) (
  // system clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // serial link from the host
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_si,
  input  wire logic i_hold_n,
  // hardware write protect
  input  wire logic i_wp_n,
  // serial data out, three-state
  output logic      o_so,
  output logic      o_so_oe_n
);
  import sec_pkg::*;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef struct packed {
    sec_phase_e                 phase;
    sec_cmd_e                   kind;
    logic [2:0]                 bitcnt;
    logic [7:0]                 sh;
    logic [7:0]                 addr;
    logic [7:0]                 tx;
    logic [7:0]                 stat;
    logic                       aligned;
    logic [PAGE_BYTES-1:0]      mask;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
  } sec_sck_s;

  typedef struct packed {
    logic so;
    logic oe_n;
  } sec_out_s;

  typedef struct packed {
    logic       cs_prev;
    logic       busy_prev;
    logic       latch;
    logic [1:0] bp;
    logic [3:0] page;
    logic       wr;
  } sec_sys_s;

  localparam sec_out_s OUT_IDLE  = '{so: 1'b0, oe_n: 1'b1};
  localparam sec_sys_s SYS_RESET = '{cs_prev: CS_PREV_RESET, busy_prev: 1'b0, latch: LATCH_RESET,
                                     bp: BP_RESET, page: 4'h0, wr: 1'b0};

  sec_sck_s   s_r;
  sec_sck_s   s_nxt;
  sec_sck_s   cur;
  sec_out_s   o_r;
  sec_out_s   o_nxt;
  sec_sys_s   q_r;
  sec_sys_s   q_nxt;
  logic       armed_r;
  logic       frame_rst;
  logic       tri_req;
  logic [7:0] sh_in;
  logic       last;
  logic [3:0] st_s;
  logic [1:0] pins_s;
  logic       cs_s;
  logic       wp_s;
  logic       commit;
  logic       set_ok;
  logic       we;
  logic [3:0] widx;
  logic [7:0] waddr;
  logic [7:0] mem [MEM_WORDS];

  sec_wc_if wc ();

  // ---------------------------------------------------------------
  // crossings and write-cycle timer
  // ---------------------------------------------------------------
  sec_sync #(.W(2)) u_sync_pins (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_d      ({i_cs_n, i_wp_n}),
    .o_q      (pins_s)
  );

  // status bits seen by the link: {bp, latch, busy}
  sec_sync #(.W(4)) u_sync_stat (
    .i_clock  (i_sck),
    .i_resetn (i_resetn),
    .i_d      ({q_r.bp, q_r.latch, wc.busy}),
    .o_q      (st_s)
  );

  sec_wc_timer #(.CYCLES(WC_CYCLES_P)) u_timer (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .wc       (wc)
  );

  assign cs_s = pins_s[1];
  assign wp_s = pins_s[0];

  // ---------------------------------------------------------------
  // link side, rising clock edge
  // ---------------------------------------------------------------
  assign frame_rst = i_cs_n | ~i_resetn;

  // marks the first rising edge after select falls
  always_ff @(posedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      armed_r <= 1'b0;
    end else if (i_hold_n) begin
      armed_r <= 1'b1;
    end
  end

  always_comb begin
    cur = s_r;
    if (!armed_r) begin
      cur.phase   = SEC_OPC;
      cur.bitcnt  = BIT_FIRST;
      cur.aligned = 1'b0;
      cur.kind    = SEC_NONE;
    end
    sh_in = {cur.sh[6:0], i_si};
    last  = (cur.bitcnt == BIT_LAST);
    s_nxt = cur;
    // a paused edge changes nothing, so the bit position survives
    if (i_hold_n) begin
      s_nxt.sh      = sh_in;
      s_nxt.bitcnt  = cur.bitcnt + BIT_ONE;
      s_nxt.aligned = 1'b0;
      if (last) begin
        case (cur.phase)
          SEC_OPC: begin
            s_nxt.kind = sec_decode(sh_in);
            case (sec_decode(sh_in))
              SEC_READ, SEC_WRITE: begin
                s_nxt.phase = st_s[BUSY_BIT] ? SEC_IGN : SEC_ADDR;
              end
              SEC_SET, SEC_CLR: begin
                s_nxt.phase   = SEC_DONE;
                s_nxt.aligned = 1'b1;
              end
              SEC_SRD: begin
                s_nxt.phase = SEC_SOUT;
                s_nxt.tx    = {STATUS_PAD, st_s};
              end
              SEC_SWR: begin
                s_nxt.phase = SEC_SIN;
              end
              default: begin
                s_nxt.phase = SEC_IGN;
              end
            endcase
          end
          SEC_ADDR: begin
            s_nxt.addr = sh_in;
            if (cur.kind == SEC_READ) begin
              s_nxt.phase = SEC_RDATA;
              s_nxt.tx    = mem[sh_in];
            end else begin
              s_nxt.phase = SEC_WDATA;
              s_nxt.mask  = '0;
            end
          end
          SEC_RDATA: begin
            // eight-bit pointer rolls over on its own
            s_nxt.addr = cur.addr + ADDR_STEP;
            s_nxt.tx   = mem[cur.addr + ADDR_STEP];
          end
          SEC_WDATA: begin
            s_nxt.pbuf[cur.addr[3:0]] = sh_in;
            s_nxt.mask[cur.addr[3:0]] = 1'b1;
            s_nxt.addr[3:0]           = cur.addr[3:0] + PAGE_STEP;
            s_nxt.aligned             = 1'b1;
          end
          SEC_SOUT: begin
            s_nxt.tx = {STATUS_PAD, st_s};
          end
          SEC_SIN: begin
            s_nxt.stat    = sh_in;
            s_nxt.aligned = 1'b1;
            s_nxt.phase   = SEC_DONE;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // link side, falling clock edge: data out
  // ---------------------------------------------------------------
  assign tri_req = i_cs_n | ~i_hold_n | ~i_resetn;

  always_comb begin
    o_nxt.so   = s_r.tx[BIT_LAST - s_r.bitcnt];
    o_nxt.oe_n = !(armed_r && (s_r.phase == SEC_RDATA || s_r.phase == SEC_SOUT));
  end

  // select high or a pause turns the driver off at once
  always_ff @(negedge i_sck or posedge tri_req) begin
    if (tri_req) begin
      o_r <= OUT_IDLE;
    end else begin
      o_r <= o_nxt;
    end
  end

  assign o_so      = o_r.so;
  assign o_so_oe_n = o_r.oe_n;

  // ---------------------------------------------------------------
  // system side: commit on select rise, latch, protect bits
  // ---------------------------------------------------------------
  // commit reads link state while select is high and the clock stands; the page copy reads pbuf and mask whatever select does
  always_comb begin
    q_nxt           = q_r;
    wc.start        = 1'b0;
    q_nxt.cs_prev   = cs_s;
    q_nxt.busy_prev = wc.busy;
    commit          = cs_s && !q_r.cs_prev && s_r.aligned;
    set_ok          = commit && (s_r.kind == SEC_SET) && wp_s;
    if (q_r.busy_prev && !wc.busy) begin
      q_nxt.latch = 1'b0;
      q_nxt.wr    = 1'b0;
    end
    if (commit) begin
      case (s_r.kind)
        SEC_SET: begin
          if (wp_s) begin
            q_nxt.latch = 1'b1;
          end
        end
        SEC_CLR: begin
          q_nxt.latch = 1'b0;
        end
        SEC_SWR: begin
          if (wp_s && q_r.latch && !wc.busy) begin
            q_nxt.bp    = s_r.stat[BP_LO_BIT +: 2];
            q_nxt.latch = 1'b0;
            wc.start    = 1'b1;
          end
        end
        SEC_WRITE: begin
          if (wp_s && q_r.latch && !wc.busy) begin
            q_nxt.page = s_r.addr[7:4];
            q_nxt.wr   = 1'b1;
            wc.start   = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // protect pin wins over a set in the same cycle
    if (!wp_s) begin
      q_nxt.latch = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      q_r <= SYS_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // array: page copied one byte a cycle at the start of the cycle
  // ---------------------------------------------------------------
  assign widx  = wc.count[3:0];
  assign waddr = {q_r.page, widx};
  // a running cycle ignores the protect pin
  assign we    = wc.busy && q_r.wr && (wc.count < PAGE_CNT) && s_r.mask[widx]
                 && !sec_protected(waddr, q_r.bp);

  always_ff @(posedge i_clock) begin
    if (we) begin
      mem[waddr] <= s_r.pbuf[widx];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  latch_pin_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !wp_s |=> !q_r.latch)
    else $error("latch set while protect pin low");

  latch_end_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    ($fell(wc.busy) && !set_ok) |=> !q_r.latch)
    else $error("latch survived end of write cycle");

  latch_set_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    $rose(q_r.latch) |-> $past(set_ok))
    else $error("latch set without a completed enable frame");

  protect_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    we |-> (q_r.bp == 2'h0 || (q_r.bp == 2'h1 && waddr < PROT_QTR) || (q_r.bp == 2'h2 && waddr < PROT_HALF))
           && wc.count < PAGE_CNT)
    else $error("write into protected range");

  off_deselect_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_cs_n |-> o_so_oe_n)
    else $error("output driven while deselected");

  read_refuse_a: assert property (@(posedge i_sck) disable iff (!i_resetn)
    (i_hold_n && cur.phase == SEC_OPC && last && sec_decode(sh_in) == SEC_READ && st_s[BUSY_BIT])
    |=> s_r.phase == SEC_IGN)
    else $error("array read accepted while busy");

  write_decode_a: assert property (@(posedge i_sck) disable iff (!i_resetn)
    (i_hold_n && cur.phase == SEC_OPC && last && sec_decode(sh_in) == SEC_WRITE && !st_s[BUSY_BIT])
    |=> s_r.phase == SEC_ADDR ##8 s_r.phase == SEC_WDATA || !i_hold_n || !armed_r)
    else $error("write opcode not followed by address");

  read_wrap_a: assert property (@(posedge i_sck) disable iff (!i_resetn)
    (i_hold_n && cur.phase == SEC_RDATA && last) |=> s_r.addr == 8'($past(s_r.addr) + ADDR_STEP))
    else $error("read pointer did not advance");

  page_wrap_a: assert property (@(posedge i_sck) disable iff (!i_resetn)
    (i_hold_n && cur.phase == SEC_WDATA && last) |=> s_r.addr[7:4] == $past(s_r.addr[7:4]))
    else $error("write left its page");

  hold_keep_a: assert property (@(posedge i_sck) disable iff (!i_resetn)
    (!i_hold_n && armed_r) |=> $stable(s_r.bitcnt) && $stable(s_r.sh))
    else $error("paused edge moved the bit position");

  status_a: assert property (@(posedge i_sck) disable iff (!i_resetn)
    (i_hold_n && cur.phase == SEC_OPC && last && sec_decode(sh_in) == SEC_SRD)
    |=> s_r.tx[1:0] == $past(st_s[1:0]))
    else $error("status byte does not show busy and latch");

  cover_read: cover property (@(posedge i_sck) disable iff (!i_resetn)
    s_r.phase == SEC_RDATA ##8 s_r.phase == SEC_RDATA);
  cover_write: cover property (@(posedge i_clock) disable iff (!i_resetn) $rose(wc.busy) && q_nxt.wr);
  cover_status: cover property (@(posedge i_sck) disable iff (!i_resetn) s_r.phase == SEC_SOUT);
  cover_swr: cover property (@(posedge i_clock) disable iff (!i_resetn) commit && s_r.kind == SEC_SWR);
endmodule : sec_engine
`default_nettype wire

// *** sec_host.sv ***
// host-side serial master model for the eeprom link
`timescale 1ns/10ps
`default_nettype none
module sec_host (
  // link to the device
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n,
  // link from the device
  input  wire logic i_so,
  input  wire logic i_so_oe_n
);
  logic [7:0] rx;
  logic       chk = 1'b0;
  event       got;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  task automatic sel();
    o_cs_n = 1'b0;
    #30;
  endtask : sel
  // released data line shows the inverse so nothing reads a stale bit
  task automatic desel();
    #30 o_cs_n = 1'b1;
    o_si = ~o_si;
    #600;
  endtask : desel
  // pause entered and left with the clock low, two clock pulses and junk on the data line meanwhile
  task automatic pause();
    o_hold_n = 1'b0;
    repeat (2) begin
      o_si = ~o_si;
      #7.5 o_sck = 1'b1;
      #7.5 o_sck = 1'b0;
    end
    o_hold_n = 1'b1;
  endtask : pause
  task automatic xbits(input logic [7:0] b, input int nb, input bit pz);
    for (int i = 7; i > 7 - nb; i--) begin
      if (pz && i == 3) pause();
      o_si = b[i];
      #7.5 o_sck = 1'b1;
      rx = {rx[6:0], i_so_oe_n ? 1'bx : i_so};
      #7.5 o_sck = 1'b0;
    end
    if (nb == 8) begin
      ->got;
      #1;
    end
  endtask : xbits
endmodule : sec_host
`default_nettype wire

// *** tb_sec_engine.sv ***
// self-checking bench of the serial eeprom command engine
`timescale 1ns/10ps
`default_nettype none
module tb_sec_engine;
  import sec_pkg::*;
  // ----------------------------------------
  // clock, design and host
  // ----------------------------------------
  localparam logic [WC_CNT_W-1:0] WCC = 16'h0028;
  logic       i_clock = 1'b0;
  logic       i_resetn = 1'b0;
  logic       i_wp_n = 1'b1;
  logic       sck, cs_n, si, hold_n, so, so_oe_n;
  int         failures, n_compared, seed;
  logic [7:0] mem_m [256];
  logic [7:0] exp_q [$];
  logic [1:0] bp_m;
  always #50 i_clock = ~i_clock;
  sec_engine #(.WC_CYCLES_P(WCC)) dut_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe_n(so_oe_n));
  sec_host host_u (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n), .i_so(so), .i_so_oe_n(so_oe_n));
  // ----------------------------------------
  // compare, frame and command tasks
  // ----------------------------------------
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: byte %h, expected %h", $time, g, e);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: flag %b, expected %b", $time, g, e);
    end
  endtask : cmp_bit
  always @(host_u.got) if (host_u.chk) cmp_byte(exp_q.pop_front(), host_u.rx);
  // bit 3 random on every opcode
  function automatic logic [7:0] opc(input logic [2:0] c);
    return {4'h0, 1'($random(seed)), c};
  endfunction : opc
  task automatic op1(input logic [2:0] c);
    host_u.sel();
    host_u.xbits(opc(c), 8, 1'b0);
    host_u.desel();
  endtask : op1
  task automatic fr(input logic [2:0] c, input logic [7:0] a, input bit ad, input int n, input bit pz, input bit ck);
    host_u.sel();
    host_u.xbits(opc(c), 8, 1'b0);
    if (ad) host_u.xbits(a, 8, pz);
    host_u.chk = ck;
    repeat (n) host_u.xbits(8'h00, 8, 1'b0);
    host_u.chk = 1'b0;
    host_u.desel();
  endtask : fr
  task automatic sts(input logic [7:0] e);
    exp_q.push_back(e);
    fr(OPC_SRD, 8'h00, 1'b0, 1, 1'b0, 1'b1);
  endtask : sts
  task automatic rd(input logic [7:0] a, input int n, input bit pz);
    for (int k = 0; k < n; k++) exp_q.push_back(mem_m[8'(a + k)]);
    fr(OPC_READ, a, 1'b1, n, pz, 1'b1);
  endtask : rd
  // poll busy with a bound; limit covers the shortened write cycle
  task automatic settle(input bit cb);
    int k;
    k = 0;
    do begin
      fr(OPC_SRD, 8'h00, 1'b0, 1, 1'b0, 1'b0);
      if (cb && k == 0) cmp_bit(1'b1, host_u.rx[0]);
      k++;
    end while (host_u.rx[0] !== 1'b0 && k < 8);
    cmp_bit(1'b0, host_u.rx[0]);
    sts({4'h0, bp_m, 2'b00});
  endtask : settle
  task automatic wr(input logic [7:0] a, input int n, input bit keep);
    logic [7:0] d;
    op1(OPC_SET);
    host_u.sel();
    host_u.xbits(opc(OPC_WRITE), 8, 1'b0);
    host_u.xbits(a, 8, 1'b0);
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      if (!keep) mem_m[{a[7:4], a[3:0] + 4'(k)}] = d;
      host_u.xbits(d, 8, 1'b0);
    end
    host_u.desel();
    if (keep) op1(OPC_CLR);
    else begin
      host_u.sel();
      host_u.xbits(opc(OPC_READ), 8, 1'b0);
      host_u.xbits(a, 8, 1'b0);
      host_u.xbits(8'h00, 8, 1'b0);
      cmp_bit(1'b1, so_oe_n);
      host_u.desel();
    end
    settle(!keep);
  endtask : wr
  task automatic sws(input logic [7:0] v);
    op1(OPC_SET);
    host_u.sel();
    host_u.xbits(opc(OPC_SWR), 8, 1'b0);
    host_u.xbits(v, 8, 1'b0);
    host_u.desel();
    bp_m = v[3:2];
    settle(1'b1);
  endtask : sws
  task automatic complete_run();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    #1000000;
    failures++;
    complete_run();
  end
  initial begin
    seed = 48674;
    failures = 0;
    n_compared = 0;
    bp_m = 2'h0;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock) i_resetn = 1'b1;
    repeat (4) @(negedge i_clock);
    cmp_bit(1'b1, so_oe_n);
    wr(8'h7c, 6, 1'b0);
    wr(8'hfe, 4, 1'b0);
    wr(8'h00, 2, 1'b0);
    rd(8'h7c, 4, 1'b0);
    rd(8'h70, 2, 1'b1);
    rd(8'hfe, 4, 1'b0);
    sws(8'hf4);
    wr(8'hf0, 1, 1'b1);
    rd(8'hf0, 2, 1'b0);
    sws(8'h00);
    op1(OPC_SET);
    host_u.sel();
    host_u.xbits(opc(OPC_WRITE), 8, 1'b0);
    host_u.xbits(8'h70, 8, 1'b0);
    host_u.xbits(8'h55, 4, 1'b0);
    host_u.desel();
    sts(8'h02);
    op1(OPC_CLR);
    sts(8'h00);
    host_u.sel();
    host_u.xbits(opc(OPC_SET), 8, 1'b0);
    host_u.xbits(8'h00, 8, 1'b0);
    host_u.desel();
    sts(8'h00);
    host_u.sel();
    host_u.xbits(8'h07, 8, 1'b0);
    host_u.xbits(8'h00, 8, 1'b0);
    cmp_bit(1'b1, so_oe_n);
    host_u.desel();
    op1(OPC_SET);
    @(negedge i_clock) i_wp_n = 1'b0;
    repeat (4) @(negedge i_clock);
    sts(8'h00);
    op1(OPC_SET);
    sts(8'h00);
    @(negedge i_clock) i_wp_n = 1'b1;
    complete_run();
  end
endmodule : tb_sec_engine
`default_nettype wire
